// ### hw/tsp_pkg.sv
// Package with constants for the three-wire serial port
// Functional notes
// - Serial clock is the oscillator input rate divided by sixteen, synchronous.
// - Serial clock runs continuously on its pin, never gated between words.
// - Receive enable bit is sampled on the rising serial clock edge.
// - Receive data bits are sampled on the falling serial clock edge.
// - Transmit enable bit is launched at the falling serial clock edge.
// - Transmit data bits are launched at the rising serial clock edge.
// - A word starts with enable high; sixteen bits follow while enable stays high.
// - Serial output pin is always driven, never high impedance.
// - Chip reset returns the port to its idle state.
package tsp_pkg;
   localparam int unsigned CLK_DIV      = 16;
   localparam int unsigned HALF_DIV     = CLK_DIV / 2;
   localparam int unsigned DIV_W        = 4;
   localparam int unsigned WORD_W       = 16;
   localparam int unsigned BIT_CNT_W    = 5;
   localparam logic [3:0]  DIV_RISE     = 4'h0;
   localparam logic [3:0]  DIV_FALL     = 4'h8;
   localparam logic [15:0] WORD_RESET   = 16'h0000;
endpackage

// ### hw/tsp_serial_port.sv
// Three-wire serial port: clock divider, shift registers and enable framing
`timescale 1ns/10ps
module tsp_serial_port #(
   parameter int unsigned WORD_W = tsp_pkg::WORD_W
) (
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic              clk_en,
   input  wire logic              oscillator_input,
   input  wire logic              serial_in,
   input  wire logic              tx_valid,
   output logic                   tx_ready,
   input  wire logic [WORD_W-1:0] tx_word,
   output logic                   serial_clk,
   output logic                   serial_out,
   output logic [WORD_W-1:0]      rx_word,
   output logic                   rx_done,
   output logic                   tx_done
);
   // Oscillator input arrives as a pin; it is treated as a sampled level and
   // its rising edges drive the divider, keeping everything on clk.
   logic       osc_s1_reg, osc_s2_reg, osc_s3_reg;
   logic       si_s1_reg, si_s2_reg, si_s3_reg, si_val_reg;
   logic       osc_tick;
   logic [3:0] div_reg;
   logic       sclk_rise, sclk_fall;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         osc_s1_reg <= 1'b0;
         osc_s2_reg <= 1'b0;
         osc_s3_reg <= 1'b0;
         si_s1_reg  <= 1'b0;
         si_s2_reg  <= 1'b0;
         si_s3_reg  <= 1'b0;
         si_val_reg <= 1'b0;
      end else if (clk_en) begin
         osc_s1_reg <= oscillator_input;
         osc_s2_reg <= osc_s1_reg;
         osc_s3_reg <= osc_s2_reg;
         si_s1_reg  <= serial_in;
         si_s2_reg  <= si_s1_reg;
         si_s3_reg  <= si_s2_reg;
         if (si_s2_reg == si_s3_reg) begin
            si_val_reg <= si_s3_reg;
         end
      end
   end

   assign osc_tick = osc_s2_reg & ~osc_s3_reg;

   // Free-running divide by sixteen of the oscillator; no stop condition exists
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div_reg <= 4'h0;
      end else if (clk_en && osc_tick) begin
         div_reg <= div_reg + 4'h1;
      end
   end

   // Divider decode shared by both serial clock edges; the edge is taken on
   // the tick that moves the divider onto the edge position
   function automatic logic div_hit(input logic [3:0] cnt, input logic [3:0] mark);
      return cnt == (mark - 4'h1);
   endfunction

   assign sclk_rise = clk_en & osc_tick & div_hit(div_reg, tsp_pkg::DIV_RISE);
   assign sclk_fall = clk_en & osc_tick & div_hit(div_reg, tsp_pkg::DIV_FALL);

   // Edges must alternate; the divider leaves reset nearer the falling edge
   logic last_rise_reg;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         last_rise_reg <= 1'b1;
      end else if (sclk_rise) begin
         last_rise_reg <= 1'b1;
      end else if (sclk_fall) begin
         last_rise_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         serial_clk <= 1'b0;
      end else if (sclk_rise) begin
         serial_clk <= 1'b1;
      end else if (sclk_fall) begin
         serial_clk <= 1'b0;
      end
   end

   // Receive side: enable on rising edge, data on following falling edge
   logic [WORD_W-1:0]  rx_sh_reg;
   logic [4:0]         rx_cnt_reg;
   logic               rx_en_reg;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_en_reg  <= 1'b0;
         rx_cnt_reg <= 5'h00;
         rx_sh_reg  <= '0;
         rx_word    <= '0;
         rx_done    <= 1'b0;
      end else if (clk_en) begin
         rx_done <= 1'b0;
         if (sclk_rise) begin
            rx_en_reg <= si_val_reg;
            if (!si_val_reg) begin
               rx_cnt_reg <= 5'h00;
            end
         end else if (sclk_fall && rx_en_reg) begin
            rx_sh_reg <= {rx_sh_reg[WORD_W-2:0], si_val_reg};
            if (rx_cnt_reg == 5'(WORD_W - 1)) begin
               rx_cnt_reg <= 5'h00;
               rx_word    <= {rx_sh_reg[WORD_W-2:0], si_val_reg};
               rx_done    <= 1'b1;
            end else begin
               rx_cnt_reg <= rx_cnt_reg + 5'h01;
            end
         end
      end
   end

   // Transmit side: pin carries enable in low phase, data in high phase
   logic [WORD_W-1:0]  tx_sh_reg;
   logic [4:0]         tx_cnt_reg;
   logic               tx_busy_reg;
   // Set only when an enable was launched for the current word
   logic               tx_armed_reg;

   assign tx_ready = ~tx_busy_reg;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_busy_reg <= 1'b0;
         tx_cnt_reg  <= 5'h00;
         tx_sh_reg   <= tsp_pkg::WORD_RESET;
         serial_out  <= 1'b0;
         tx_done     <= 1'b0;
      end else if (clk_en) begin
         tx_done <= 1'b0;
         if (!tx_busy_reg && tx_valid) begin
            tx_busy_reg <= 1'b1;
            tx_sh_reg   <= tx_word;
            tx_cnt_reg  <= 5'h00;
         end
         if (sclk_fall) begin
            serial_out <= tx_busy_reg;
         end else if (sclk_rise) begin
            // A word taken after the falling edge waits one serial period,
            // otherwise the far side would see data with no enable ahead
            if (tx_busy_reg && tx_armed_reg) begin
               serial_out <= tx_sh_reg[WORD_W-1];
               tx_sh_reg  <= {tx_sh_reg[WORD_W-2:0], 1'b0};
               if (tx_cnt_reg == 5'(WORD_W - 1)) begin
                  tx_busy_reg <= 1'b0;
                  tx_done     <= 1'b1;
               end else begin
                  tx_cnt_reg <= tx_cnt_reg + 5'h01;
               end
            end else begin
               serial_out <= 1'b0;
            end
         end
      end
   end

   // A word accepted mid-phase must see enable launched before data
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_armed_reg <= 1'b0;
      end else if (clk_en) begin
         if (sclk_fall) begin
            tx_armed_reg <= tx_busy_reg;
         end
      end
   end

   a_rise_fall_excl: assert property (@(posedge clk) disable iff (!arst_n)
      !(sclk_rise && sclk_fall)) else $error("serial clock edges collide");
   a_sclk_toggles: assert property (@(posedge clk) disable iff (!arst_n)
      sclk_rise |=> serial_clk) else $error("serial clock did not rise");
   a_sclk_falls: assert property (@(posedge clk) disable iff (!arst_n)
      sclk_fall |=> !serial_clk) else $error("serial clock did not fall");
   a_rx_en_cap: assert property (@(posedge clk) disable iff (!arst_n)
      sclk_rise |=> rx_en_reg == $past(si_val_reg)) else $error("receive enable not captured");
   a_rx_shift: assert property (@(posedge clk) disable iff (!arst_n)
      (sclk_fall && rx_en_reg) |=> rx_sh_reg[0] == $past(si_val_reg)) else $error("receive bit lost");
   a_tx_en_out: assert property (@(posedge clk) disable iff (!arst_n)
      sclk_fall |=> serial_out == $past(tx_busy_reg)) else $error("transmit enable wrong");
   a_tx_msb: assert property (@(posedge clk) disable iff (!arst_n)
      (sclk_rise && tx_busy_reg && tx_armed_reg) |=> serial_out == $past(tx_sh_reg[WORD_W-1]))
      else $error("transmit bit wrong");
   a_done_count: assert property (@(posedge clk) disable iff (!arst_n)
      rx_done |-> $past(rx_cnt_reg) == 5'(WORD_W - 1)) else $error("receive done early");
   a_out_known: assert property (@(posedge clk) disable iff (!arst_n)
      (sclk_rise && !tx_busy_reg) |=> !serial_out) else $error("idle data not low");
   a_tx_armed: assert property (@(posedge clk) disable iff (!arst_n)
      (tx_busy_reg && sclk_fall) |=> tx_armed_reg) else $error("enable not framed");
   a_data_framed: assert property (@(posedge clk) disable iff (!arst_n)
      (sclk_rise && tx_busy_reg && !tx_armed_reg) |=> !serial_out) else $error("data sent without enable");
   a_rise_alternate: assert property (@(posedge clk) disable iff (!arst_n)
      sclk_rise |-> !last_rise_reg) else $error("two rising edges in a row");
   a_fall_alternate: assert property (@(posedge clk) disable iff (!arst_n)
      sclk_fall |-> last_rise_reg) else $error("two falling edges in a row");
   a_sclk_steady: assert property (@(posedge clk) disable iff (!arst_n)
      !(sclk_rise || sclk_fall) |=> $stable(serial_clk)) else $error("serial clock moved off an edge");
   a_div_hold: assert property (@(posedge clk) disable iff (!arst_n)
      !(clk_en && osc_tick) |=> $stable(div_reg)) else $error("divider moved without a tick");
   a_tx_done_count: assert property (@(posedge clk) disable iff (!arst_n)
      tx_done |-> $past(tx_cnt_reg) == 5'(WORD_W - 1)) else $error("transmit done early");
   a_tx_done_pulse: assert property (@(posedge clk) disable iff (!arst_n)
      tx_done |=> !tx_done) else $error("transmit done too long");
   a_rx_done_pulse: assert property (@(posedge clk) disable iff (!arst_n)
      rx_done |=> !rx_done) else $error("receive done too long");
   a_rx_word_hold: assert property (@(posedge clk) disable iff (!arst_n)
      (rx_word != $past(rx_word)) |-> rx_done) else $error("receive word changed between words");
   a_tx_cnt_range: assert property (@(posedge clk) disable iff (!arst_n)
      tx_cnt_reg < 5'(WORD_W)) else $error("transmit count out of range");
   a_rx_cnt_range: assert property (@(posedge clk) disable iff (!arst_n)
      rx_cnt_reg < 5'(WORD_W)) else $error("receive count out of range");
endmodule

// ### bench/tsp_codec.sv
// Far-side codec model: sends and receives one word per frame
`timescale 1ns/10ps
module tsp_codec (
   input  wire logic        clk,
   input  wire logic        serial_clk,
   input  wire logic        serial_out,
   output logic             serial_in,
   input  wire logic [15:0] send_word,
   input  wire logic        send_go,
   output logic [15:0]      got_word,
   output logic [7:0]       got_cnt,
   output logic [7:0]       period
);
   logic        sc_q = 0, out_q = 0, en_q = 0, rise, fall;
   logic [4:0]  tx_left = 0, rx_left = 0;
   logic [7:0]  ph = 0, per = 0;
   logic [15:0] sh = 0;
   assign rise = sc_q === 1'b0 && serial_clk === 1'b1;
   assign fall = sc_q === 1'b1 && serial_clk === 1'b0;
   initial {serial_in, got_word, got_cnt, period} = '0;
   always @(posedge clk) begin
      sc_q <= serial_clk;
      out_q <= serial_out;
      ph <= (rise || fall) ? 8'h00 : ph + 8'h01;
      per <= rise ? 8'h01 : per + 8'h01;
      if (rise) begin
         period <= per;
         if (out_q && rx_left == 0) rx_left <= 5'h10;
      end
      if (fall && rx_left != 0) begin
         got_word <= {got_word[14:0], out_q};
         rx_left <= rx_left - 5'h01;
         got_cnt <= got_cnt + 8'(rx_left == 5'h01);
      end
      // Pin changes mid-phase so it is steady across the sampling edge
      if (send_go) begin
         sh <= send_word;
         tx_left <= 5'h10;
      end else if (ph == 8'h14 && !serial_clk) begin
         en_q <= tx_left != 0;
         serial_in <= tx_left != 0;
      end else if (ph == 8'h14 && en_q) begin
         serial_in <= sh[15];
         sh <= sh << 1;
         tx_left <= tx_left - 5'h01;
      end else if (ph == 8'h14) begin
         serial_in <= ~serial_in;
      end
   end
endmodule

// ### bench/tsp_serial_port_test.sv
// Self-checking bench for the three-wire serial port
`timescale 1ns/10ps
module tsp_serial_port_test;
   logic        clk = 0, arst_n = 0, osc = 0, tx_valid = 0, go = 0;
   logic        serial_in, tx_ready, serial_clk, serial_out, rx_done, tx_done;
   logic [15:0] tx_word = 0, p_word = 0, rx_word, got_word;
   logic [7:0]  got_cnt, period;
   logic [15:0] corner [3] = '{16'h8001, 16'hffff, 16'h0000};
   int          fails = 0, check_count = 0, cyc = 0, txn = 0, rxn = 0;
   int          seed = 32'hf1e9b440;
   always #4 clk = ~clk;
   // Oscillator phase is offset from clk on purpose
   initial #3 forever #24 osc = ~osc;
   tsp_serial_port dut (.clk(clk), .arst_n(arst_n), .clk_en(1'b1), .oscillator_input(osc),
      .serial_in(serial_in), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_word(tx_word),
      .serial_clk(serial_clk), .serial_out(serial_out), .rx_word(rx_word), .rx_done(rx_done),
      .tx_done(tx_done));
   tsp_codec codec (.clk(clk), .serial_clk(serial_clk), .serial_out(serial_out),
      .serial_in(serial_in), .send_word(p_word), .send_go(go), .got_word(got_word),
      .got_cnt(got_cnt), .period(period));
   function automatic logic [15:0] exp_period();
      return 16'(16 * 48 / 8);
   endfunction
   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic xfer(input logic [15:0] a, input logic [15:0] b);
      int t0, r0, g0;
      t0 = txn;
      r0 = rxn;
      g0 = got_cnt;
      p_word <= b;
      go <= 1;
      tx_word <= a;
      tx_valid <= 1;
      do @(posedge clk); while (tx_ready !== 1'b1);
      go <= 0;
      tx_valid <= 0;
      repeat (4000) if (txn == t0 + 1 && rxn == r0 + 1 && got_cnt == 8'(g0 + 1)) break; else @(posedge clk);
      cmp("rx_word", b, rx_word);
      cmp("far side word", a, got_word);
      cmp("word counts", 16'h0101, {8'(txn - t0), 8'(rxn - r0)});
   endtask
   always @(posedge clk) begin
      cyc++;
      if (tx_done) txn++;
      if (rx_done) rxn++;
      if (arst_n) cmp("serial_out driven", 16'h1, 16'(serial_out === 1'b0 || serial_out === 1'b1));
      if (cyc == 60000) begin
         fails++;
         final_report();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      cmp("reset outputs", 16'h0010, {11'h0, tx_ready, serial_out, serial_clk, tx_done, rx_done});
      arst_n <= 1;
      repeat (300) @(posedge clk);
      cmp("idle serial period", exp_period(), {8'h0, period});
      foreach (corner[i]) xfer(corner[i], ~corner[i]);
      repeat (6) xfer(16'($random(seed)), 16'($random(seed)));
      cmp("serial period", exp_period(), {8'h0, period});
      tx_word <= 16'h1234;
      tx_valid <= 1;
      @(posedge clk);
      tx_valid <= 0;
      repeat (700) @(posedge clk);
      arst_n <= 0;
      @(posedge clk);
      @(posedge clk);
      cmp("mid reset outputs", 16'h0010, {11'h0, tx_ready, serial_out, serial_clk, tx_done, rx_done});
      arst_n <= 1;
      repeat (3000) @(posedge clk);
      xfer(16'($random(seed)), 16'h8000);
      final_report();
   end
endmodule
